// >>> rtl/asof_pkg.sv
// Purpose: shared constants for the serial output framer of a multichannel converter
// Assumes: 100 MHz mclk, 32-bit Avalon-MM register bus with word-aligned byte addresses
// Notes: register offsets and fields are named here; pin bit positions and the header packing are literals in the logic
package asof_pkg;
  // converter geometry
  localparam int NUM_CH = 8;                 // channels on the larger part
  localparam int NUM_CH_SMALL = 4;           // channels on the smaller part
  localparam int WORD_W = 32;                // bits per channel slot
  localparam int DATA_W = 24;                // conversion value width
  localparam int RAW_W = 28;                 // unclipped filter output width
  localparam int HDR_W = 8;                  // status header width
  localparam int BITCNT_W = 8;               // counts up to 8 slots of 32 bits
  // header bit positions
  localparam int HDR_FATAL = 7;              // fatal-fault flag
  localparam int HDR_UNSETTLED = 6;          // filter not settled
  localparam int HDR_REPEAT = 5;             // repeated-data slot
  localparam int HDR_FILT = 4;               // 0 wideband, 1 low latency
  localparam int HDR_SAT = 3;                // filter output clipped
  // clipping limits of the 24-bit value
  localparam logic signed [RAW_W-1:0] CLIP_MAX = 28'sh07fffff;
  localparam logic signed [RAW_W-1:0] CLIP_MIN = -28'sh0800000;
  // pin-mode settings
  localparam logic [3:0] MODE_FAST_DIV4 = 4'ha;
  localparam logic [3:0] MODE_FAST_DIV1 = 4'h8;
  localparam logic [3:0] MODE_MED_DIV1 = 4'h4;
  // bit clock half periods in mclk cycles
  localparam logic [1:0] HALF_DIV4 = 2'h2;   // bit period of 4 mclk cycles
  localparam logic [1:0] HALF_DIV1 = 2'h1;   // fastest a flop-made clock can run
  // power-up capture: cycles for the pin synchronisers to fill
  localparam logic [1:0] PWRUP_FILL = 2'h3;
  // register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FILT = 4'h1;
  localparam logic [3:0] REG_SLOW = 4'h2;
  localparam logic [3:0] REG_SETTLE = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // control register fields
  localparam int CTRL_REGMODE = 0;           // 1 = register control
  localparam int CTRL_DIV1 = 1;              // register mode: undivided bit clock
  localparam int CTRL_PWR_LO = 2;            // register mode: power mode field
  localparam int CTRL_PWR_HI = 3;
  // status register fields
  localparam int ST_FATAL = 0;
  localparam int ST_UNSETTLED = 1;
  localparam int ST_OVERRUN = 2;             // write one to clear
  localparam int ST_CAPTURED = 3;
  localparam int ST_LANES_LO = 4;            // log2 of lanes in use
  localparam int ST_LANES_HI = 5;
  localparam int ST_SMALL = 6;
  // reset values and power mode codes
  localparam logic [15:0] SETTLE_RST = 16'h0004;
  localparam logic [1:0] PWR_FAST = 2'h0;
  localparam logic [1:0] PWR_MEDIAN = 2'h1;
  localparam logic [1:0] PWR_ECO = 2'h2;
  typedef enum logic [1:0] {FR_IDLE, FR_STROBE, FR_SHIFT} asof_frame_t;
endpackage

// >>> rtl/asof_framer.sv
// Purpose: pack channel results into header+value words and stream them on 1 to 8 lanes
// Assumes: lane-select, part and mode pins are asynchronous; conversion inputs are on mclk
// Notes: the device is master of the link; bit clock is a flop output derived from mclk

// Function
// - lane select caught once after power-up
// - bit clock within data rate and mclk
// - large part, 00: one lane per channel
// - 01: ch0-3 lane 0, ch4-7 lane 1
// - upper bit set: all channels on lane 0
// - small part: own lanes or lane 0
// - word is header then 24-bit value
// - header flag order fixed, then channel id
// - fatal flag sticky until reset
// - clock missing sends zero values
// - not-settled until settling count elapses
// - slow channel repeats: flag set, zero value
// - filter flag from pin or per channel
// - clip at full scale, flag saturation
// - channel id is binary channel number
// - device drives data, bit clock, strobe
// - strobe one bit before first header bit
// - strobe fall starts frame, 8+24 bits
// - pin modes pick power and divider
// - not-settled flag in header bit 6
module asof_framer
  import asof_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // straps and pins (asynchronous)
  input wire logic lane_select_low,
  input wire logic lane_select_high,
  input wire logic part_small,
  input wire logic [3:0] mode_pins,
  input wire logic filter_pin,
  // converter core events (mclk domain)
  input wire logic conv_valid,
  input wire logic [NUM_CH*RAW_W-1:0] conv_data,
  input wire logic sync_req,
  input wire logic clk_missing,
  input wire logic cfg_fault,
  input wire logic crc_fault,
  // serial link
  output logic data_bit_clock,
  output logic frame_strobe_n,
  output logic [NUM_CH-1:0] serial_data_lane,
  output logic [1:0] power_mode,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [7:0] pin_ok_r;                      // last agreed pin value
  logic [1:0] pwrup_cnt_r;                   // fill time after reset
  logic captured_r;                          // lane config taken
  logic ls_low_r, ls_high_r, small_r;        // captured straps
  // configuration registers
  logic [31:0] ctrl_r;
  logic [NUM_CH-1:0] filt_r;                 // per-channel filter type
  logic [NUM_CH-1:0] slow_r;                 // channels at half rate
  logic [15:0] settle_r;
  // status
  logic fatal_r, overrun_r, pending_r, parity_r;
  logic [15:0] conv_cnt_r;
  logic unsettled;
  // bit clock
  logic [1:0] half_r, phase_r;
  logic fall_tick, rise_tick;
  // frame engine
  asof_frame_t state_r;
  logic [BITCNT_W-1:0] bit_cnt_r, last_bit;
  logic [1:0] lanes_log, cpl_log;
  logic frame_start, frame_end;
  logic [WORD_W-1:0] word_r [NUM_CH];
  logic [NUM_CH-1:0] lane_nxt;
  logic ack_r;
  logic reg_mode;

  assign reg_mode = ctrl_r[CTRL_REGMODE];

  // three-stage pin chain; only stage two feeds stage three
  always_ff @(posedge mclk) begin
    pin_s1_r <= {filter_pin, mode_pins, part_small, lane_select_high, lane_select_low};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    if (pin_s2_r == pin_s3_r) begin
      pin_ok_r <= pin_s3_r;
    end
  end

  // capture lane straps once after reset; later pin changes are ignored
  always_ff @(posedge mclk) begin
    if (srst) begin
      pwrup_cnt_r <= 2'h0;
      captured_r <= 1'b0;
      ls_low_r <= 1'b0;
      ls_high_r <= 1'b0;
      small_r <= 1'b0;
    end else if (!captured_r) begin
      if (pwrup_cnt_r != PWRUP_FILL) begin
        pwrup_cnt_r <= pwrup_cnt_r + 2'h1;
      end else if (pin_s2_r == pin_s3_r) begin
        captured_r <= 1'b1;
        ls_low_r <= pin_s3_r[0];
        ls_high_r <= pin_s3_r[1];
        small_r <= pin_s3_r[2];
      end
    end
  end

  // lane count and channels per lane from the captured straps
  always_comb begin
    if (small_r) begin
      lanes_log = ls_low_r ? 2'h0 : 2'h2;
      cpl_log = ls_low_r ? 2'h2 : 2'h0;
    end else if (ls_high_r) begin
      lanes_log = 2'h0;
      cpl_log = 2'h3;
    end else if (ls_low_r) begin
      lanes_log = 2'h1;
      cpl_log = 2'h2;
    end else begin
      lanes_log = 2'h3;
      cpl_log = 2'h0;
    end
  end

  assign last_bit = BITCNT_W'((WORD_W << cpl_log) - 1);

  // power mode and divider: pin setting in pin mode, control field otherwise
  always_ff @(posedge mclk) begin
    if (srst) begin
      power_mode <= PWR_FAST;
    end else if (reg_mode) begin
      power_mode <= ctrl_r[CTRL_PWR_HI:CTRL_PWR_LO];
    end else begin
      case (pin_ok_r[6:3])
        MODE_FAST_DIV4: power_mode <= PWR_FAST;
        MODE_FAST_DIV1: power_mode <= PWR_FAST;
        MODE_MED_DIV1: power_mode <= PWR_MEDIAN;
        default: power_mode <= PWR_ECO;
      endcase
    end
  end

  // bit clock: low half then high half; divider only changes between frames
  always_ff @(posedge mclk) begin
    if (srst) begin
      half_r <= HALF_DIV4;
      phase_r <= 2'h0;
      data_bit_clock <= 1'b0;
    end else begin
      if (fall_tick && state_r == FR_IDLE && !frame_start) begin
        if (reg_mode) begin
          half_r <= ctrl_r[CTRL_DIV1] ? HALF_DIV1 : HALF_DIV4;
        end else begin
          half_r <= (pin_ok_r[6:3] == MODE_FAST_DIV4) ? HALF_DIV4 : HALF_DIV1;
        end
      end
      if (phase_r == {half_r[1], 1'b1}) begin  // last phase: twice the half minus one
        phase_r <= 2'h0;
      end else begin
        phase_r <= phase_r + 2'h1;
      end
      if (fall_tick) begin
        data_bit_clock <= 1'b0;            // data changes here, receiver samples on rise
      end else if (rise_tick) begin
        data_bit_clock <= 1'b1;
      end
    end
  end

  assign fall_tick = (phase_r == 2'h0);
  assign rise_tick = (phase_r == half_r);

  // settling: conversions counted since reset or sync
  always_ff @(posedge mclk) begin
    if (srst || sync_req) begin
      conv_cnt_r <= 16'h0000;
    end else if (conv_valid && unsettled) begin
      conv_cnt_r <= conv_cnt_r + 16'h0001;
    end
  end

  assign unsettled = (conv_cnt_r < settle_r);

  // fatal fault: sticky, only reset clears it
  always_ff @(posedge mclk) begin
    if (srst) begin
      fatal_r <= 1'b0;
    end else if (clk_missing || cfg_fault || crc_fault) begin
      fatal_r <= 1'b1;
    end
  end

  // pending result and overrun; a new result beats the clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      pending_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (conv_valid) begin
        pending_r <= 1'b1;
      end else if (frame_start) begin
        pending_r <= 1'b0;
      end
      if (conv_valid && pending_r && !frame_start) begin
        overrun_r <= 1'b1;
      end else if (avs_write && ack_r && avs_address == REG_STATUS && avs_byteenable[0] &&
                   avs_writedata[ST_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
    end
  end

  assign frame_start = fall_tick && pending_r && captured_r &&
                       (state_r == FR_IDLE || (state_r == FR_SHIFT && bit_cnt_r == last_bit));
  assign frame_end = fall_tick && state_r == FR_SHIFT && bit_cnt_r == last_bit;

  // build one word per channel at frame start
  always_ff @(posedge mclk) begin
    if (srst) begin
      parity_r <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        word_r[c] <= '0;
      end
    end else if (frame_start) begin
      parity_r <= ~parity_r;
      for (int c = 0; c < NUM_CH; c++) begin
        logic signed [RAW_W-1:0] raw;
        logic [DATA_W-1:0] val;
        logic sat, rep, ftype;
        raw = conv_data[c*RAW_W +: RAW_W];
        sat = 1'b0;
        if (raw > CLIP_MAX) begin
          val = CLIP_MAX[DATA_W-1:0];
          sat = 1'b1;
        end else if (raw < CLIP_MIN) begin
          val = CLIP_MIN[DATA_W-1:0];
          sat = 1'b1;
        end else begin
          val = raw[DATA_W-1:0];
        end
        rep = reg_mode && slow_r[c] && parity_r;
        ftype = reg_mode ? filt_r[c] : pin_ok_r[7];
        if (rep || clk_missing) begin
          val = '0;
        end
        word_r[c][WORD_W-1:DATA_W] <= {fatal_r, unsettled, rep, ftype, sat && !rep,
                                       3'(c)};
        word_r[c][DATA_W-1:0] <= val;
      end
    end
  end

  // frame sequencer: strobe low for one bit, then msb-first shifting
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= FR_IDLE;
      bit_cnt_r <= '0;
      frame_strobe_n <= 1'b1;
    end else if (fall_tick) begin
      case (state_r)
        FR_IDLE: begin
          if (frame_start) begin
            state_r <= FR_STROBE;
            frame_strobe_n <= 1'b0;
          end
        end
        FR_STROBE: begin
          state_r <= FR_SHIFT;
          frame_strobe_n <= 1'b1;
          bit_cnt_r <= '0;
        end
        FR_SHIFT: begin
          if (frame_start) begin
            state_r <= FR_STROBE;
            frame_strobe_n <= 1'b0;
          end else if (frame_end) begin
            state_r <= FR_IDLE;
          end else begin
            bit_cnt_r <= bit_cnt_r + BITCNT_W'(1);
          end
        end
        default: begin
          state_r <= FR_IDLE;
          frame_strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // lane mux: lane l carries channels l*cpl .. l*cpl+cpl-1 in slot order
  always_comb begin
    logic [BITCNT_W-1:0] bc;
    logic [2:0] slot, ch;
    logic [4:0] pos;
    bc = '0;
    slot = '0;
    ch = '0;
    pos = '0;
    lane_nxt = '0;
    bc = (state_r == FR_STROBE) ? '0 : bit_cnt_r + BITCNT_W'(1);
    slot = bc[7:5];
    pos = 5'h1f - bc[4:0];
    for (int l = 0; l < NUM_CH; l++) begin
      ch = 3'((l << cpl_log) + slot);
      if (l < (1 << lanes_log) && (state_r == FR_STROBE ||
          (state_r == FR_SHIFT && bit_cnt_r != last_bit))) begin
        lane_nxt[l] = word_r[ch][pos];
      end
    end
  end

  // lane outputs change on the falling bit clock edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_data_lane <= '0;
    end else if (fall_tick) begin
      serial_data_lane <= lane_nxt;
    end
  end

  // register writes, byte-lane aware; taken at the edge that completes the access
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r <= '0;
      filt_r <= '0;
      slow_r <= '0;
      settle_r <= SETTLE_RST;
    end else if (avs_write && ack_r && avs_byteenable[0]) begin
      case (avs_address)
        REG_CTRL: ctrl_r[7:0] <= avs_writedata[7:0];
        REG_FILT: filt_r <= avs_writedata[7:0];
        REG_SLOW: slow_r <= avs_writedata[7:0];
        REG_SETTLE: settle_r[7:0] <= avs_writedata[7:0];
        default: ;
      endcase
      if (avs_address == REG_SETTLE && avs_byteenable[1]) begin
        settle_r[15:8] <= avs_writedata[15:8];
      end
    end else if (avs_write && ack_r && avs_address == REG_SETTLE && avs_byteenable[1]) begin
      settle_r[15:8] <= avs_writedata[15:8];
    end
  end

  // one wait cycle per access, then read data registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_r <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r) begin
        case (avs_address)
          REG_CTRL: avs_readdata <= ctrl_r;
          REG_FILT: avs_readdata <= {24'h000000, filt_r};
          REG_SLOW: avs_readdata <= {24'h000000, slow_r};
          REG_SETTLE: avs_readdata <= {16'h0000, settle_r};
          REG_STATUS: begin
            avs_readdata <= '0;
            avs_readdata[ST_FATAL] <= fatal_r;
            avs_readdata[ST_UNSETTLED] <= unsettled;
            avs_readdata[ST_OVERRUN] <= overrun_r;
            avs_readdata[ST_CAPTURED] <= captured_r;
            avs_readdata[ST_LANES_HI:ST_LANES_LO] <= lanes_log;
            avs_readdata[ST_SMALL] <= small_r;
          end
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
endmodule

// >>> bench/asof_framer_assertions.sv
// Purpose: concurrent checks on the framer's serial link and bus
// Assumes: lane straps held steady while srst is high
// Notes: straps are latched during reset, ahead of the framer's own capture
module asof_framer_chk
  import asof_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // straps
  input wire logic lane_select_low,
  input wire logic lane_select_high,
  input wire logic part_small,
  // serial link
  input wire logic data_bit_clock,
  input wire logic frame_strobe_n,
  input wire logic [NUM_CH-1:0] serial_data_lane,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cap_r; // small, high, low as seen in reset
  logic dbc_q_r; // bit clock one mclk ago
  logic [3:0] rise_r; // bit clock rises while strobe is low
  logic [15:0] bits_r; // bit clock rises since the frame start
  logic seen_r; // a frame has started since reset
  logic [15:0] need; // least bits from one frame start to the next
  assign need = 16'h1 + ((cap_r[1] && !cap_r[2]) ? 16'h100 : (cap_r[0] ? 16'h80 : 16'h20));
  // strap latch and bit clock history
  always_ff @(posedge mclk) begin
    if (srst) begin
      cap_r <= {part_small, lane_select_high, lane_select_low};
    end
    dbc_q_r <= data_bit_clock;
  end
  // rises inside the strobe bit
  always_ff @(posedge mclk) begin
    if (srst || frame_strobe_n) rise_r <= 4'h0;
    else if (data_bit_clock && !dbc_q_r) rise_r <= rise_r + 4'h1;
  end
  // rises since the last frame start
  always_ff @(posedge mclk) begin
    if (srst) begin
      bits_r <= 16'h0;
      seen_r <= 1'b0;
    end else if ($fell(frame_strobe_n)) begin
      bits_r <= 16'h0;
      seen_r <= 1'b1;
    end else if (data_bit_clock && !dbc_q_r) begin
      bits_r <= bits_r + 16'h1;
    end
  end
  chk_one_lane: assert property (@(posedge mclk) disable iff (srst)
    ((cap_r[1] && !cap_r[2]) || (cap_r[2] && cap_r[0])) |-> serial_data_lane[7:1] == 7'h0)
    else $error("data seen on a lane that should be idle");
  chk_two_lanes: assert property (@(posedge mclk) disable iff (srst)
    cap_r == 3'h1 |-> serial_data_lane[7:2] == 6'h0)
    else $error("data seen beyond lane 1");
  chk_small_lanes: assert property (@(posedge mclk) disable iff (srst)
    cap_r[2] |-> serial_data_lane[7:4] == 4'h0)
    else $error("small part drove an upper lane");
  chk_strobe_width: assert property (@(posedge mclk) disable iff (srst)
    $rose(frame_strobe_n) |-> rise_r == 4'h1)
    else $error("strobe low for other than one bit");
  chk_strobe_edge: assert property (@(posedge mclk) disable iff (srst)
    $fell(frame_strobe_n) |-> $fell(data_bit_clock))
    else $error("strobe fell off the bit clock fall");
  chk_data_edge: assert property (@(posedge mclk) disable iff (srst)
    !$stable(serial_data_lane) |-> $fell(data_bit_clock))
    else $error("lane data moved off the bit clock fall");
  chk_frame_len: assert property (@(posedge mclk) disable iff (srst)
    $fell(frame_strobe_n) && seen_r |-> bits_r >= need)
    else $error("frame started before the last one ended");
  chk_bus_answer: assert property (@(posedge mclk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

bind asof_framer asof_framer_chk asof_framer_chk_i (.mclk(mclk), .srst(srst),
  .lane_select_low(lane_select_low), .lane_select_high(lane_select_high),
  .part_small(part_small), .data_bit_clock(data_bit_clock),
  .frame_strobe_n(frame_strobe_n), .serial_data_lane(serial_data_lane),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// >>> bench/asof_rx_model.sv
// Purpose: receiving fpga model that deframes the serial result stream
// Assumes: the bench tells it lanes in use and slots per lane
// Notes: each word is filed under the channel id in its own header
module asof_rx_model
  import asof_pkg::*;
(
  // link from the framer
  input wire logic data_bit_clock,
  input wire logic frame_strobe_n,
  input wire logic [NUM_CH-1:0] serial_data_lane,
  // receiver setup
  input wire logic [3:0] lanes_used,
  input wire logic [3:0] slots
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh [NUM_CH]; // per-lane shift registers
  logic [31:0] rx_ch [NUM_CH]; // last word per channel id
  int lane_of [NUM_CH]; // lane that carried each channel
  int words; // words received so far
  int nbit; // bits since the frame start
  logic armed; // inside a frame
  initial begin
    armed = 1'b0;
    words = 0;
    nbit = 0;
  end
  // capture on the rising bit clock, frame starts on a low strobe
  always @(posedge data_bit_clock) begin
    if (!frame_strobe_n) begin
      armed = 1'b1;
      nbit = 0;
    end else if (armed) begin
      for (int l = 0; l < int'(lanes_used); l++) begin
        sh[l] = {sh[l][30:0], serial_data_lane[l]};
        if (nbit % 32 == 31) begin
          rx_ch[sh[l][26:24]] = sh[l];
          lane_of[sh[l][26:24]] = l;
          words++;
        end
      end
      nbit++;
      if (nbit == 32 * int'(slots)) armed = 1'b0;
    end
  end
endmodule

// >>> bench/test_asof_framer.sv
// Purpose: self-checking bench for the serial output framer
// Assumes: one conversion per frame, straps steady across each reset
// Notes: each lane setting is entered through its own reset
module test_asof_framer
  import asof_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs
  logic mclk, srst, lane_select_low, lane_select_high, part_small, filter_pin;
  logic conv_valid, sync_req, clk_missing, cfg_fault, crc_fault, avs_read, avs_write;
  logic [3:0] mode_pins, avs_address, avs_byteenable;
  logic [NUM_CH*RAW_W-1:0] conv_data;
  logic [31:0] avs_writedata;
  // design outputs
  logic data_bit_clock, frame_strobe_n, avs_waitrequest;
  logic [NUM_CH-1:0] serial_data_lane;
  logic [1:0] power_mode;
  logic [31:0] avs_readdata;
  // receiver setup and bookkeeping
  logic [3:0] m_lanes, m_slots;
  logic [31:0] rd;
  int bad_count, compares, per;

  asof_framer asof_framer_i (.mclk, .srst, .lane_select_low, .lane_select_high, .part_small,
    .mode_pins, .filter_pin, .conv_valid, .conv_data, .sync_req, .clk_missing, .cfg_fault,
    .crc_fault, .data_bit_clock, .frame_strobe_n, .serial_data_lane, .power_mode,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest);
  asof_rx_model asof_rx_model_i (.data_bit_clock, .frame_strobe_n, .serial_data_lane,
    .lanes_used(m_lanes), .slots(m_slots));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // raw filter output per channel; 1 and 2 overrange
  function automatic logic signed [RAW_W-1:0] raw(int c);
    if (c == 1) return 28'sh0900000;
    if (c == 2) return -28'sh0900000;
    return 28'sh0012340 + RAW_W'(c);
  endfunction
  // expected word: header flags, id, clipped or zeroed value
  function automatic logic [31:0] ew(int c, logic f, logic u, logic t, logic z);
    logic signed [RAW_W-1:0] x;
    logic [23:0] v;
    logic s;
    x = raw(c);
    s = (x > CLIP_MAX) || (x < CLIP_MIN);
    v = (x > CLIP_MAX) ? 24'h7fffff : ((x < CLIP_MIN) ? 24'h800000 : x[23:0]);
    return {f, u, 1'b0, t, s, 3'(c), z ? 24'h0 : v};
  endfunction
  task automatic results();
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rst(input logic sm, input logic hi, input logic lo, input logic [3:0] md);
    part_small <= sm;
    lane_select_high <= hi;
    lane_select_low <= lo;
    mode_pins <= md;
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // one conversion; measures the bit period and waits for nw words
  task automatic frame(input int nw);
    int w0, n;
    realtime t0;
    w0 = asof_rx_model_i.words;
    conv_valid <= 1'b1;
    @(posedge mclk);
    conv_valid <= 1'b0;
    @(posedge data_bit_clock);
    t0 = $realtime;
    @(posedge data_bit_clock);
    per = int'(($realtime - t0) / 10.0);
    n = 0;
    do begin @(posedge mclk); n++; end while (asof_rx_model_i.words < w0 + nw && n < 9000);
    chk(32'(n < 9000), 32'h1);
  endtask
  task automatic check_all(input int nch, input int cpl, input logic f, input logic u,
                           input logic [7:0] ft, input logic z, input logic [31:0] m);
    for (int c = 0; c < nch; c++) begin
      chk(32'(asof_rx_model_i.lane_of[c]), 32'(c / cpl));
      chk(asof_rx_model_i.rx_ch[c] & m, ew(c, f, u, ft[c], z) & m);
    end
  endtask
  // hang guard
  initial begin
    #400000;
    bad_count++;
    results();
  end
  initial begin
    {srst, conv_valid, sync_req, clk_missing, cfg_fault, crc_fault} = 6'h20;
    {lane_select_low, lane_select_high, part_small, filter_pin, avs_read, avs_write} = 6'h4;
    {mode_pins, avs_address, avs_byteenable, avs_writedata} = {12'ha0f, 32'h0};
    {m_lanes, m_slots, bad_count, compares, per} = {8'h81, 96'h0};
    for (int c = 0; c < NUM_CH; c++) conv_data[c*RAW_W +: RAW_W] = raw(c);
    // eight dedicated lanes, divided clock, then undivided after mode pins 4'h4
    rst(1'b0, 1'b0, 1'b0, 4'ha);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h3a);
    frame(8);
    chk(32'(per), 32'h4);
    chk(32'(power_mode), 32'h0);
    check_all(8, 1, 1'b0, 1'b1, 8'hff, 1'b0, '1);
    lane_select_high <= 1'b1;
    filter_pin <= 1'b0;
    repeat (5) frame(8);
    check_all(8, 1, 1'b0, 1'b0, 8'h00, 1'b0, '1);
    sync_req <= 1'b1;
    @(posedge mclk);
    sync_req <= 1'b0;
    frame(8);
    check_all(8, 1, 1'b0, 1'b1, 8'h00, 1'b0, '1);
    mode_pins <= 4'h4;
    repeat (8) @(posedge mclk);
    frame(8);
    chk(32'(per), 32'h2);
    chk(32'(power_mode), 32'h1);
    // two shared lanes, undivided clock
    {m_lanes, m_slots} <= 8'h24;
    rst(1'b0, 1'b0, 1'b1, 4'h8);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h1a);
    frame(8);
    chk(32'(per), 32'h2);
    chk(32'(power_mode), 32'h0);
    check_all(8, 4, 1'b0, 1'b1, 8'h00, 1'b0, '1);
    // one lane under register control
    {m_lanes, m_slots} <= 8'h18;
    rst(1'b0, 1'b1, 1'b1, 4'ha);
    bus(REG_CTRL, 1'b1, 32'h1, rd);
    bus(REG_FILT, 1'b1, 32'h0f, rd);
    bus(4'hf, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    frame(8);
    check_all(8, 8, 1'b0, 1'b1, 8'h0f, 1'b0, '1);
    bus(REG_SLOW, 1'b1, 32'h80, rd);
    frame(8);
    rd = asof_rx_model_i.rx_ch[7];
    frame(8);
    chk(32'(rd[29] ^ asof_rx_model_i.rx_ch[7][29]), 32'h1);
    chk((rd[29] ? rd : asof_rx_model_i.rx_ch[7]) & 32'h20ffffff, 32'h20000000);
    bus(REG_SLOW, 1'b1, 32'h0, rd);
    clk_missing <= 1'b1;
    repeat (4) @(posedge mclk);
    frame(8);
    check_all(8, 8, 1'b1, 1'b0, 8'h0f, 1'b1, 32'hb7ffffff);
    clk_missing <= 1'b0;
    frame(8);
    check_all(8, 8, 1'b1, 1'b0, 8'h0f, 1'b0, 32'hbfffffff);
    // small part, one shared lane
    m_slots <= 4'h4;
    rst(1'b1, 1'b0, 1'b1, 4'ha);
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h4a);
    frame(4);
    check_all(4, 4, 1'b0, 1'b1, 8'h00, 1'b0, '1);
    crc_fault <= 1'b1;
    @(posedge mclk);
    crc_fault <= 1'b0;
    bus(REG_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h4b);
    results();
  end
endmodule
